// ===== design/bsc_retry.sv
// Current-limit counter and restart timer
module bsc_retry
    import bsc_pkg::*;
#(
    parameter int RETRY_WAIT = RETRY_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    bsc_fault_if.guard flt
);
    localparam int TW = $clog2(RETRY_WAIT + 1);
    logic [4:0] hits, next_hits;
    logic [TW-1:0] timer, next_timer;
    logic next_trip, next_waiting, next_retry;

    // ==========================================
    // Count consecutive limited cycles, then hold off
    always_comb begin
        next_hits = hits;
        next_timer = timer;
        next_waiting = flt.waiting;
        next_trip = 1'b0;
        next_retry = 1'b0;
        if (flt.cancel) begin
            next_hits = 5'h00;
            next_timer = '0;
            next_waiting = 1'b0;
        end else if (flt.waiting) begin
            if (timer == TW'(RETRY_WAIT - 1)) begin
                next_waiting = 1'b0;
                next_retry = 1'b1;
                next_timer = '0;
            end else begin
                next_timer = timer + 1'b1;
            end
        end else if (flt.armed && flt.cycle_edge) begin
            if (!flt.limit_hit) begin
                next_hits = 5'h00;
            end else if (hits == 5'(LIMIT_CYCLES - 1)) begin
                next_hits = 5'h00;
                next_trip = 1'b1;
                next_waiting = 1'b1;
            end else begin
                next_hits = hits + 5'h01;
            end
        end
    end

    // Register guard state
    always_ff @(posedge clock) begin
        if (reset) begin
            hits <= 5'h00;
            timer <= '0;
            flt.trip <= 1'b0;
            flt.waiting <= 1'b0;
            flt.retry <= 1'b0;
        end else begin
            hits <= next_hits;
            timer <= next_timer;
            flt.trip <= next_trip;
            flt.waiting <= next_waiting;
            flt.retry <= next_retry;
        end
    end
endmodule

// ===== design/bsc_sync.sv
// Two-stage synchronizer for asynchronous pin inputs
module bsc_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // ==========================================
    // Per-bit flop pair; first stage feeds only the second
    logic [WIDTH-1:0] meta;
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clock) begin
            if (reset) begin
                meta[i] <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                meta[i] <= async_in[i];
                sync_out[i] <= meta[i];
            end
        end
    end
endmodule

// ===== design/bsc_top.sv
// Enable, bank select and soft-start sequencer of the step-down regulator
module bsc_top
    import bsc_pkg::*;
#(
    parameter int RETRY_WAIT = RETRY_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic en_pin,
    input wire logic voltage_bank_select_pin,
    input wire logic current_limit_hit,
    input wire logic switch_cycle,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,
    output logic irq,
    output logic internal_power_on,
    output logic regulator_on,
    output logic switch_hiz,
    output logic sync_rect_en,
    output logic forced_pwm_mode,
    output logic [VOLT_W-1:0] reference_code,
    output logic [VOLT_W-1:0] vout_code,
    output logic [SLEW_W-1:0] slew_rate_code,
    output logic discharge_on
);
    // ==========================================
    // Pin synchronization
    logic [3:0] pins_s;
    logic en_s, sel_s, limit_s, cycle_s, cycle_d;
    bsc_sync #(.WIDTH(4)) bsc_sync_inst (
        .clock(clock),
        .reset(reset),
        .async_in({switch_cycle, current_limit_hit, voltage_bank_select_pin, en_pin}),
        .sync_out(pins_s)
    );
    assign en_s = pins_s[0];
    assign sel_s = pins_s[1];
    assign limit_s = pins_s[2];
    assign cycle_s = pins_s[3];

    // Delayed copy for switching-cycle edge detection
    always_ff @(posedge clock) begin
        if (reset) begin
            cycle_d <= 1'b0;
        end else begin
            cycle_d <= cycle_s;
        end
    end

    // ==========================================
    // Register file
    logic [DATA_W-1:0] bank0_voltage_reg, bank1_voltage_reg, control_reg;
    logic [DATA_W-1:0] next_bank0, next_bank1, next_control, next_rdata;
    logic [IRQ_W-1:0] irq_status, irq_mask, next_irq_status, next_irq_mask, events;
    logic [DATA_W-1:0] status_word;
    bsc_state_t state, next_state;

    // Writes and sticky event bits; a new event beats a clear
    always_comb begin
        next_bank0 = bank0_voltage_reg;
        next_bank1 = bank1_voltage_reg;
        next_control = control_reg;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        if (reg_write) begin
            if (reg_addr == REG_BANK0) begin
                next_bank0 = reg_wdata;
            end else if (reg_addr == REG_BANK1) begin
                next_bank1 = reg_wdata;
            end else if (reg_addr == REG_CONTROL) begin
                next_control = reg_wdata;
            end else if (reg_addr == REG_IRQ_STATUS) begin
                next_irq_status = irq_status & ~reg_wdata[IRQ_W-1:0];
            end else if (reg_addr == REG_IRQ_MASK) begin
                next_irq_mask = reg_wdata[IRQ_W-1:0];
            end
        end
        next_irq_status = next_irq_status | events;
    end

    // Read mux; data valid only in the cycle after the strobe
    always_comb begin
        next_rdata = 8'h00;
        if (reg_read) begin
            if (reg_addr == REG_BANK0) begin
                next_rdata = bank0_voltage_reg;
            end else if (reg_addr == REG_BANK1) begin
                next_rdata = bank1_voltage_reg;
            end else if (reg_addr == REG_CONTROL) begin
                next_rdata = control_reg;
            end else if (reg_addr == REG_STATUS) begin
                next_rdata = status_word;
            end else if (reg_addr == REG_IRQ_STATUS) begin
                next_rdata = {5'h00, irq_status};
            end else if (reg_addr == REG_IRQ_MASK) begin
                next_rdata = {5'h00, irq_mask};
            end
        end
    end

    // Only the power-on reset returns defaults; the enable pin never touches them
    always_ff @(posedge clock) begin
        if (reset) begin
            bank0_voltage_reg <= BANK0_RESET;
            bank1_voltage_reg <= BANK1_RESET;
            control_reg <= CONTROL_RESET;
            irq_status <= 3'h0;
            irq_mask <= IRQ_MASK_RESET;
            reg_rdata <= 8'h00;
        end else begin
            bank0_voltage_reg <= next_bank0;
            bank1_voltage_reg <= next_bank1;
            control_reg <= next_control;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            reg_rdata <= next_rdata;
        end
    end

    // ==========================================
    // Enable decode
    logic bank_on, enabled, mode_bit;
    logic [VOLT_W-1:0] target;
    assign bank_on = sel_s ? bank1_voltage_reg[BANK_ON_BIT] : bank0_voltage_reg[BANK_ON_BIT];
    assign enabled = en_s & bank_on;
    assign target = sel_s ? bank1_voltage_reg[VOLT_W-1:0] : bank0_voltage_reg[VOLT_W-1:0];
    assign mode_bit = sel_s ? control_reg[CTRL_MODE1_BIT] : control_reg[CTRL_MODE0_BIT];

    // ==========================================
    // Retry guard
    bsc_fault_if flt ();
    assign flt.armed = (state == ST_SOFTSTART) || (state == ST_RUN);
    assign flt.cancel = ~enabled;
    assign flt.cycle_edge = cycle_s & ~cycle_d;
    assign flt.limit_hit = limit_s;
    bsc_retry #(.RETRY_WAIT(RETRY_WAIT)) bsc_retry_inst (
        .clock(clock),
        .reset(reset),
        .flt(flt)
    );

    // ==========================================
    // Sequencer
    logic [VOLT_W-1:0] ramp, next_ramp;
    logic [8:0] step, next_step;
    logic ss_done;

    // Next state, reference ramp and step divider
    always_comb begin
        next_state = state;
        next_ramp = ramp;
        next_step = 9'h000;
        ss_done = 1'b0;
        case (state)
            ST_OFF: begin
                next_ramp = 7'h00;
                if (enabled) begin
                    next_state = ST_SOFTSTART;
                end
            end
            ST_SOFTSTART: begin
                if (!enabled) begin
                    next_state = ST_OFF;
                end else if (flt.trip) begin
                    next_state = ST_RETRY_WAIT;
                end else if (step != 9'(SS_STEP_CYCLES - 1)) begin
                    next_step = step + 9'h001;
                end else if (ramp >= target) begin
                    next_state = ST_RUN;
                    ss_done = 1'b1;
                end else begin
                    next_ramp = ramp + 7'h01;
                end
            end
            ST_RUN: begin
                next_ramp = target;
                if (!enabled) begin
                    next_state = ST_OFF;
                end else if (flt.trip) begin
                    next_state = ST_RETRY_WAIT;
                end
            end
            ST_RETRY_WAIT: begin
                next_ramp = 7'h00;
                if (!enabled) begin
                    next_state = ST_OFF;
                end else if (flt.retry) begin
                    next_state = ST_SOFTSTART;
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
    end
    assign events = {flt.retry, flt.trip, ss_done};

    // Register sequencer state
    always_ff @(posedge clock) begin
        if (reset) begin
            state <= ST_OFF;
            ramp <= 7'h00;
            step <= 9'h000;
        end else begin
            state <= next_state;
            ramp <= next_ramp;
            step <= next_step;
        end
    end

    // ==========================================
    // Status and registered outputs
    logic active;
    assign active = (next_state == ST_SOFTSTART) || (next_state == ST_RUN);
    assign status_word = {state == ST_RUN, state == ST_SOFTSTART, flt.waiting,
                          forced_pwm_mode, 1'b0, bank_on, sel_s, en_s};

    // Output flops fed from next-state decode, en_s, sel_s and the register file
    always_ff @(posedge clock) begin
        if (reset) begin
            irq <= 1'b0;
            internal_power_on <= 1'b0;
            regulator_on <= 1'b0;
            switch_hiz <= 1'b1;
            sync_rect_en <= 1'b0;
            forced_pwm_mode <= 1'b0;
            reference_code <= 7'h00;
            vout_code <= 7'h00;
            slew_rate_code <= 3'h0;
            discharge_on <= 1'b0;
        end else begin
            irq <= |(next_irq_status & next_irq_mask);
            internal_power_on <= en_s;
            regulator_on <= active;
            switch_hiz <= ~active;
            sync_rect_en <= next_state == ST_RUN;
            forced_pwm_mode <= active & (sel_s | mode_bit);
            reference_code <= next_ramp;
            vout_code <= target;
            slew_rate_code <= control_reg[CTRL_SLEW_LSB +: SLEW_W];
            discharge_on <= control_reg[CTRL_DISCHARGE_BIT] & ~enabled;
        end
    end
endmodule

// ===== shared/bsc_fault_if.sv
// Carrier between the sequencer and the current-limit retry guard
interface bsc_fault_if;
    logic armed;
    logic cancel;
    logic cycle_edge;
    logic limit_hit;
    logic trip;
    logic waiting;
    logic retry;
    modport ctrl (output armed, output cancel, output cycle_edge, output limit_hit,
                  input trip, input waiting, input retry);
    modport guard (input armed, input cancel, input cycle_edge, input limit_hit,
                   output trip, output waiting, output retry);
endinterface

// ===== shared/bsc_pkg.sv
// Constants shared by the regulator enable and soft-start control block
package bsc_pkg;
    // ==========================================
    // Register bus geometry and offsets
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] REG_BANK0 = 8'h00;
    localparam logic [7:0] REG_BANK1 = 8'h01;
    localparam logic [7:0] REG_CONTROL = 8'h02;
    localparam logic [7:0] REG_STATUS = 8'h03;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_MASK = 8'h05;
    // ==========================================
    // Field positions
    localparam int VOLT_W = 7;
    localparam int BANK_ON_BIT = 7;
    localparam int CTRL_DISCHARGE_BIT = 7;
    localparam int CTRL_SLEW_LSB = 4;
    localparam int SLEW_W = 3;
    localparam int CTRL_MODE0_BIT = 0;
    localparam int CTRL_MODE1_BIT = 1;
    localparam int IRQ_SS_DONE = 0;
    localparam int IRQ_FAULT = 1;
    localparam int IRQ_RETRY = 2;
    localparam int IRQ_W = 3;
    // ==========================================
    // Reset values
    localparam logic [7:0] BANK0_RESET = 8'hD0;
    localparam logic [7:0] BANK1_RESET = 8'hD0;
    localparam logic [7:0] CONTROL_RESET = 8'h82;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
    // ==========================================
    // Timing at the 250 MHz internal clock
    localparam int CLK_MHZ = 250;
    localparam int RETRY_US = 1700;
    localparam int RETRY_CYCLES = RETRY_US * CLK_MHZ;
    localparam int SOFTSTART_US = 150;
    localparam int SOFTSTART_CYCLES = SOFTSTART_US * CLK_MHZ;
    localparam int SS_STEP_CYCLES = SOFTSTART_CYCLES / (1 << VOLT_W);
    localparam int LIMIT_CYCLES = 16;
    localparam int DISCHARGE_OHMS = 11;
    // ==========================================
    // Regulator states
    typedef enum logic [1:0] {ST_OFF, ST_SOFTSTART, ST_RUN, ST_RETRY_WAIT} bsc_state_t;
endpackage

// ===== testbench/bsc_power_model.sv
// Power stage model: switching cycle clock and current limit comparator
module bsc_power_model (
    input wire logic clock,
    input wire logic reset,
    input wire logic overload,
    output logic switch_cycle,
    output logic current_limit_hit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase;
    // Switching period of four clocks
    always_ff @(posedge clock) begin
        if (reset) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end
    // Limit comparator trips whenever the load is too heavy
    assign switch_cycle = phase[1];
    assign current_limit_hit = overload;
endmodule

// ===== testbench/bsc_top_asserts.sv
// Concurrent checks on the ports of the regulator enable block
module bsc_top_asserts
    import bsc_pkg::*;
#(
    parameter int RETRY_WAIT = RETRY_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic en_pin,
    input wire logic voltage_bank_select_pin,
    input wire logic reg_read,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic internal_power_on,
    input wire logic regulator_on,
    input wire logic switch_hiz,
    input wire logic sync_rect_en,
    input wire logic forced_pwm_mode,
    input wire logic [VOLT_W-1:0] reference_code
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    a_rdata_one_cycle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    a_pin_low_off: assert property (!en_pin [*6] |-> !regulator_on && !internal_power_on)
        else $error("regulator on with enable pin low");
    a_power_follows: assert property (en_pin [*6] |-> internal_power_on)
        else $error("internal power off with enable pin high");
    a_hiz_when_off: assert property (regulator_on != switch_hiz)
        else $error("switch state disagrees with regulator state");
    a_rect_needs_on: assert property (sync_rect_en |-> regulator_on)
        else $error("rectifier on while regulator off");
    a_rect_after_ramp: assert property ($rose(sync_rect_en) |-> $past(regulator_on) && !$past(sync_rect_en))
        else $error("rectifier on without soft-start");
    a_ramp_step: assert property (regulator_on && !sync_rect_en && $past(regulator_on) && !$past(sync_rect_en)
        |-> reference_code == $past(reference_code) || reference_code == $past(reference_code) + 7'h01)
        else $error("reference ramp jumped");
    a_ref_zero_off: assert property (!regulator_on && !$past(regulator_on) |-> reference_code == 7'h00)
        else $error("reference not zero while off");
    a_start_latency: assert property ($rose(regulator_on) |-> $past(en_pin, 3))
        else $error("start without synchronized enable");
    a_bank1_forced_pwm_mode: assert property (voltage_bank_select_pin [*6] ##0 regulator_on [*2] |-> forced_pwm_mode)
        else $error("bank one not forced pwm");
    // Main scenarios
    c_run: cover property ($rose(sync_rect_en));
    c_trip: cover property ($fell(regulator_on) && en_pin);
    c_forced_pwm_mode: cover property ($rose(forced_pwm_mode));
endmodule

bind bsc_top bsc_top_asserts #(.RETRY_WAIT(RETRY_WAIT)) bsc_top_asserts_inst (
    .clock(clock), .reset(reset), .en_pin(en_pin), .voltage_bank_select_pin(voltage_bank_select_pin),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .internal_power_on(internal_power_on),
    .regulator_on(regulator_on), .switch_hiz(switch_hiz), .sync_rect_en(sync_rect_en),
    .forced_pwm_mode(forced_pwm_mode), .reference_code(reference_code)
);

// ===== testbench/test_buck_enable_softstart_control.sv
// Self-checking bench of the regulator enable and soft-start block
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module test_buck_enable_softstart_control
    import bsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RW = 40;
    logic clock = 0, reset = 1, en_pin = 0, voltage_bank_select_pin = 0, overload = 0;
    logic reg_write = 0, reg_read = 0, current_limit_hit, switch_cycle, irq, internal_power_on;
    logic regulator_on, switch_hiz, sync_rect_en, forced_pwm_mode, discharge_on;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [6:0] reference_code, vout_code;
    logic [2:0] slew_rate_code;
    int error_cnt = 0, checked = 0, n;
    always #2 clock = ~clock;
    bsc_top #(.RETRY_WAIT(RW)) bsc_top_inst (.clock(clock), .reset(reset), .en_pin(en_pin),
        .voltage_bank_select_pin(voltage_bank_select_pin), .current_limit_hit(current_limit_hit),
        .switch_cycle(switch_cycle), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq), .internal_power_on(internal_power_on),
        .regulator_on(regulator_on), .switch_hiz(switch_hiz), .sync_rect_en(sync_rect_en),
        .forced_pwm_mode(forced_pwm_mode), .reference_code(reference_code), .vout_code(vout_code),
        .slew_rate_code(slew_rate_code), .discharge_on(discharge_on));
    bsc_power_model bsc_power_model_inst (.clock(clock), .reset(reset), .overload(overload),
        .switch_cycle(switch_cycle), .current_limit_hit(current_limit_hit));
    // ==========================================
    // Bus and wait helpers
    task automatic do_reset;
        @(posedge clock);
        reset <= 1;
        repeat (16) @(posedge clock);
        reset <= 0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1;
        @(posedge clock);
        reg_write <= 0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1;
        @(posedge clock);
        reg_read <= 0;
        #1;
        `CHK(nm, exp, reg_rdata);
    endtask
    task automatic wait_sig(input bit rect, input logic lvl, input int lim, output int cnt);
        #1;
        cnt = 0;
        while (((rect ? sync_rect_en : regulator_on) !== lvl) && cnt < lim) begin
            @(posedge clock);
            #1;
            cnt++;
        end
    endtask
    task automatic settle;
        repeat (8) @(posedge clock);
        #1;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_defaults;
        rd_chk(REG_BANK0, 8'hD0, "bank0");
        rd_chk(REG_BANK1, 8'hD0, "bank1");
        rd_chk(REG_CONTROL, 8'h82, "control");
        rd_chk(REG_IRQ_MASK, 8'h00, "mask");
        rd_chk(REG_IRQ_STATUS, 8'h00, "irq status");
        rd_chk(8'h3F, 8'h00, "unmapped");
    endtask
    task automatic t_pin_low;
        wr(REG_BANK0, 8'h82);
        rd_chk(REG_BANK0, 8'h82, "bank0 pin low");
        settle();
        `CHK("on pin low", 1'b0, regulator_on);
        `CHK("power pin low", 1'b0, internal_power_on);
        `CHK("discharge pin low", 1'b1, discharge_on);
        `CHK("vout bank0", 7'h02, vout_code);
    endtask
    task automatic t_start_bank0;
        wr(REG_IRQ_MASK, 8'h01);
        @(posedge clock);
        en_pin <= 1;
        wait_sig(0, 1, 20, n);
        `CHK("start latency", 3, n);
        `CHK("rect in ramp", 1'b0, sync_rect_en);
        wait_sig(1, 1, 2000, n);
        `CHK("ramp done", 1'b1, n < 2000);
        `CHK("ref at target", 7'h02, reference_code);
        `CHK("auto mode", 1'b0, forced_pwm_mode);
        `CHK("discharge run", 1'b0, discharge_on);
        `CHK("irq done", 1'b1, irq);
        rd_chk(REG_STATUS, 8'h85, "status run");
        rd_chk(REG_IRQ_STATUS, 8'h01, "status done");
        wr(REG_IRQ_STATUS, 8'h01);
        repeat (3) @(posedge clock);
        #1;
        `CHK("irq cleared", 1'b0, irq);
    endtask
    task automatic t_mode_bit;
        wr(REG_CONTROL, 8'hB3);
        settle();
        `CHK("mode bit forced_pwm_mode", 1'b1, forced_pwm_mode);
        `CHK("slew", 3'h3, slew_rate_code);
        wr(REG_CONTROL, 8'h82);
        settle();
        `CHK("mode bit auto", 1'b0, forced_pwm_mode);
    endtask
    task automatic t_bank1;
        wr(REG_BANK1, 8'h05);
        @(posedge clock);
        voltage_bank_select_pin <= 1;
        settle();
        `CHK("bank1 off", 1'b0, regulator_on);
        `CHK("discharge bank off", 1'b1, discharge_on);
        `CHK("vout bank1", 7'h05, vout_code);
        wr(REG_BANK1, 8'h85);
        wait_sig(1, 1, 3000, n);
        `CHK("bank1 run", 1'b1, n < 3000);
        `CHK("bank1 forced_pwm_mode", 1'b1, forced_pwm_mode);
        rd_chk(REG_IRQ_STATUS, 8'h01, "status bank1 done");
        wr(REG_IRQ_STATUS, 8'h01);
    endtask
    task automatic t_fault;
        @(posedge clock);
        overload <= 1;
        wait_sig(0, 0, 400, n);
        `CHK("trip", 1'b1, n < 400);
        `CHK("tri-state", 1'b1, switch_hiz);
        @(posedge clock);
        overload <= 0;
        wait_sig(0, 1, RW + 20, n);
        `CHK("wait not short", 1'b1, n >= RW - 2);
        `CHK("wait not long", 1'b1, n <= RW + 4);
        rd_chk(REG_IRQ_STATUS, 8'h06, "status fault");
        `CHK("irq masked", 1'b0, irq);
        wr(REG_IRQ_STATUS, 8'h06);
    endtask
    task automatic t_keep;
        @(posedge clock);
        en_pin <= 0;
        voltage_bank_select_pin <= 0;
        wait_sig(0, 0, 10, n);
        `CHK("off pin low", 1'b1, n < 10);
        rd_chk(REG_BANK1, 8'h85, "bank1 kept");
        do_reset();
        rd_chk(REG_BANK1, 8'hD0, "bank1 reset");
    endtask
    // ==========================================
    // Closing and sequence
    task automatic end_of_test;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #240000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        do_reset();
        t_defaults();
        t_pin_low();
        t_start_bank0();
        t_mode_bit();
        t_bank1();
        t_fault();
        t_keep();
        end_of_test();
    end
endmodule
